// [logic/cbsu_defs.svh]
`ifndef CBSU_DEFS_SVH
`define CBSU_DEFS_SVH

// ==========================================================================
// register map (byte addresses on the bus)
`define CBSU_CTRL_OFS 8'h00
`define CBSU_STATUS_OFS 8'h04
`define CBSU_COUNT_OFS 8'h08
`define CBSU_TARGET_OFS 8'h0c

// ==========================================================================
// field positions and reset values
`define CBSU_CTRL_EN_BIT 0
`define CBSU_CTRL_RST 32'h0000_0001
`define CBSU_STATUS_TAKEN_BIT 0
`define CBSU_STATUS_SKIP_BIT 1
`define CBSU_STATUS_STATE_LSB 4
`define CBSU_COUNT_RST 32'h0000_0000

// ==========================================================================
// status flag positions
`define CBSU_FLAG_C 0
`define CBSU_FLAG_Z 1
`define CBSU_FLAG_N 2
`define CBSU_FLAG_V 3
`define CBSU_FLAG_H 5

// ==========================================================================
// timing and program counter steps
`define CBSU_STEP_FALL 1
`define CBSU_SKIP_ONE_WORD 2
`define CBSU_SKIP_TWO_WORD 3

// ==========================================================================
// bus encodings
`define CBSU_HTRANS_NONSEQ 2'b10
`define CBSU_HRESP_OKAY 1'b0

`endif

// [logic/cbsu_pkg.sv]
package cbsu_pkg;

  // ========================================================================
  // decoded skip and branch operations
  typedef enum logic [4:0] {
    skip_io_bit_clear = 5'h00,
    skip_io_bit_set = 5'h01,
    branch_flag_set = 5'h02,
    branch_flag_clear = 5'h03,
    branch_equal = 5'h04,
    branch_not_equal = 5'h05,
    branch_carry_set = 5'h06,
    branch_carry_clear = 5'h07,
    branch_same_or_higher = 5'h08,
    branch_lower = 5'h09,
    branch_minus = 5'h0a,
    branch_plus = 5'h0b,
    branch_signed_ge = 5'h0c,
    branch_signed_lt = 5'h0d,
    branch_halfcarry_set = 5'h0e,
    branch_halfcarry_clear = 5'h0f
  } cbsu_op_e;

  // ========================================================================
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    CBSU_ST_IDLE = 3'b001,
    CBSU_ST_WAIT1 = 3'b010,
    CBSU_ST_WAIT2 = 3'b100
  } cbsu_state_e;

endpackage

// [logic/cbsu_cond_if.sv]
`timescale 1ns/1ps

// condition request and verdict between sequencer and evaluator
interface cbsu_cond_if;
  import cbsu_pkg::*;
  cbsu_op_e op;
  logic [2:0] sel;
  logic io_bit;
  logic [7:0] flags;
  logic taken;
  logic is_skip;

  modport eval (
    input op,
    input sel,
    input io_bit,
    input flags,
    output taken,
    output is_skip
  );

  modport user (
    output op,
    output sel,
    output io_bit,
    output flags,
    input taken,
    input is_skip
  );
endinterface

// [logic/cbsu_cond_eval.sv]
`timescale 1ns/1ps
`include "cbsu_defs.svh"

module cbsu_cond_eval
  import cbsu_pkg::*;
(
  cbsu_cond_if.eval cond
);

  logic flag_c;
  logic flag_z;
  logic flag_n;
  logic flag_v;
  logic flag_h;
  logic flag_s;

  // ========================================================================
  // flags are only read here, never written back
  assign flag_c = cond.flags[`CBSU_FLAG_C];
  assign flag_z = cond.flags[`CBSU_FLAG_Z];
  assign flag_n = cond.flags[`CBSU_FLAG_N];
  assign flag_v = cond.flags[`CBSU_FLAG_V];
  assign flag_h = cond.flags[`CBSU_FLAG_H];
  assign flag_s = flag_n ^ flag_v;

  // verdict per operation
  always_comb begin
    cond.is_skip = 1'b0;
    case (cond.op)
      skip_io_bit_clear: begin
        cond.taken = ~cond.io_bit;
        cond.is_skip = 1'b1;
      end
      skip_io_bit_set: begin
        cond.taken = cond.io_bit;
        cond.is_skip = 1'b1;
      end
      branch_flag_set: cond.taken = cond.flags[cond.sel];
      branch_flag_clear: cond.taken = ~cond.flags[cond.sel];
      branch_equal: cond.taken = flag_z;
      branch_not_equal: cond.taken = ~flag_z;
      branch_carry_set: cond.taken = flag_c;
      branch_carry_clear: cond.taken = ~flag_c;
      branch_same_or_higher: cond.taken = ~flag_c;
      branch_lower: cond.taken = flag_c;
      branch_minus: cond.taken = flag_n;
      branch_plus: cond.taken = ~flag_n;
      branch_signed_ge: cond.taken = ~flag_s;
      branch_signed_lt: cond.taken = flag_s;
      branch_halfcarry_set: cond.taken = flag_h;
      branch_halfcarry_clear: cond.taken = ~flag_h;
      default: cond.taken = 1'b0;
    endcase
  end

endmodule

// [logic/cbsu_top.sv]
// Functional notes
// - skip next instruction when io bit is zero
// - skip next instruction when io bit is one
// - flag-set branch jumps to pc plus k plus one
// - flag-clear branch jumps to pc plus k plus one
// - equal on zero set, not-equal on clear
// - carry branches follow carry flag
// - same-or-higher on carry clear, lower on set
// - minus on negative set, plus on clear
// - signed ge when negative xor overflow zero
// - signed lt when negative xor overflow one
// - halfcarry branches; flag branches take 1/2 cycles
`timescale 1ns/1ps
`include "cbsu_defs.svh"

module cbsu_top
  import cbsu_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int OFS_W = 7
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  // instruction side
  input wire logic instr_valid_i,
  input wire cbsu_op_e instr_op_i,
  input wire logic [2:0] instr_sel_i,
  input wire logic [OFS_W-1:0] instr_offset_i,
  input wire logic next_two_word_i,
  input wire logic io_bit_i,
  input wire logic [7:0] status_flags_reg_i,
  input wire logic [PC_W-1:0] program_counter_i,
  output logic instr_ready_o,
  output logic stall_o,
  output logic done_o,
  output logic taken_o,
  output logic pc_load_o,
  output logic flush_o,
  output logic [PC_W-1:0] pc_next_o
);

  // ========================================================================
  // condition evaluator
  // the verdict is combinational so an untaken offer ends in one cycle
  cbsu_cond_if cond ();

  assign cond.op = instr_op_i;
  assign cond.sel = instr_sel_i;
  assign cond.io_bit = io_bit_i;
  assign cond.flags = status_flags_reg_i;

  cbsu_cond_eval u_eval (
    .cond(cond)
  );

  // ========================================================================
  // sequencer
  // state, and the result held for the core until the next instruction
  cbsu_state_e state_q;
  cbsu_state_e state_d;
  logic [PC_W-1:0] target_q;
  logic [PC_W-1:0] target_d;
  logic done_q;
  logic done_d;
  logic taken_q;
  logic taken_d;
  logic load_q;
  logic load_d;
  logic skip_q;
  logic skip_d;
  logic [PC_W-1:0] pc_out_q;
  logic [PC_W-1:0] pc_out_d;

  // decode helpers and address arithmetic
  logic enable;
  logic accept;
  logic [PC_W-1:0] ofs_ext;
  logic [PC_W-1:0] pc_fall;
  logic [PC_W-1:0] pc_branch;
  logic [PC_W-1:0] pc_skip;

  // offset is sign extended and taken from the following address
  assign ofs_ext = PC_W'($signed(instr_offset_i));
  assign pc_fall = program_counter_i + PC_W'(`CBSU_STEP_FALL);
  assign pc_branch = pc_fall + ofs_ext;
  assign pc_skip = next_two_word_i ? program_counter_i + PC_W'(`CBSU_SKIP_TWO_WORD)
                                   : program_counter_i + PC_W'(`CBSU_SKIP_ONE_WORD);

  // offers wait while busy or disabled; nothing is lost, the core holds them
  assign instr_ready_o = enable & (state_q == CBSU_ST_IDLE);
  assign accept = instr_valid_i & instr_ready_o;

  // next state and result of the sequencer
  // a taken branch keeps the verdict and target for one busy cycle, which
  // gives the fetch side time to drop the word it already prefetched
  // hazard: next_two_word_i is read at accept and again in the first wait
  // cycle, so the fetch side must hold it steady for the whole skip
  always_comb begin
    state_d = state_q;
    target_d = target_q;
    done_d = 1'b0;
    taken_d = taken_q;
    load_d = 1'b0;
    skip_d = skip_q;
    pc_out_d = pc_out_q;
    case (state_q)
      CBSU_ST_IDLE: begin
        if (accept) begin
          taken_d = cond.taken;
          skip_d = cond.is_skip;
          if (!cond.taken) begin
            // untaken: finished in this cycle, falls through
            done_d = 1'b1;
            pc_out_d = pc_fall;
          end else if (cond.is_skip) begin
            target_d = pc_skip;
            state_d = CBSU_ST_WAIT1;
          end else begin
            target_d = pc_branch;
            state_d = CBSU_ST_WAIT1;
          end
        end
      end
      CBSU_ST_WAIT1: begin
        if (skip_q && next_two_word_i) begin
          // skipping a two-word instruction costs a third cycle
          state_d = CBSU_ST_WAIT2;
        end else begin
          done_d = 1'b1;
          load_d = 1'b1;
          pc_out_d = target_q;
          state_d = CBSU_ST_IDLE;
        end
      end
      // third cycle of a skip over a two-word instruction
      CBSU_ST_WAIT2: begin
        done_d = 1'b1;
        load_d = 1'b1;
        pc_out_d = target_q;
        state_d = CBSU_ST_IDLE;
      end
      // a corrupted state code falls back to idle
      default: begin
        state_d = CBSU_ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  // every register takes its next value on every edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= CBSU_ST_IDLE;
      target_q <= '0;
      done_q <= 1'b0;
      taken_q <= 1'b0;
      load_q <= 1'b0;
      skip_q <= 1'b0;
      pc_out_q <= '0;
    end else begin
      state_q <= state_d;
      target_q <= target_d;
      done_q <= done_d;
      taken_q <= taken_d;
      load_q <= load_d;
      skip_q <= skip_d;
      pc_out_q <= pc_out_d;
    end
  end

  // core facing results
  // done, redirect and flush are one-cycle pulses; pc and verdict hold
  // flush mirrors the redirect: the prefetched word is stale after a jump
  assign stall_o = (state_q != CBSU_ST_IDLE);
  assign done_o = done_q;
  assign taken_o = taken_q;
  assign pc_load_o = load_q;
  assign flush_o = load_q;
  assign pc_next_o = pc_out_q;

  // ========================================================================
  // bus slave: address phase capture
  // zero wait states: a write is held over to the data phase, where
  // hwdata_i stands, and a read word is latched in the address phase
  logic wr_pend_q;
  logic wr_pend_d;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic addr_phase;

  assign addr_phase = hsel_i & hready_i & (htrans_i == `CBSU_HTRANS_NONSEQ);

  // ========================================================================
  // software registers
  // control (enable), status and target are read back; the redirect
  // counter clears on any write to it; the low address byte decodes and the upper bits must be zero
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic wr_ctrl;
  logic wr_count;
  logic [31:0] status_word;
  logic [31:0] target_word;

  assign wr_ctrl = wr_pend_q & (wr_addr_q == `CBSU_CTRL_OFS);
  assign wr_count = wr_pend_q & (wr_addr_q == `CBSU_COUNT_OFS);
  assign enable = ctrl_q[`CBSU_CTRL_EN_BIT];

  // control write and redirect counter, increment applies after clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = 32'h0000_0000;
      ctrl_d[`CBSU_CTRL_EN_BIT] = hwdata_i[`CBSU_CTRL_EN_BIT];
    end
    count_d = wr_count ? `CBSU_COUNT_RST : count_q;
    if (load_d) begin
      count_d = count_d + 32'h0000_0001;
    end
  end

  // control and counter registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `CBSU_CTRL_RST;
      count_q <= `CBSU_COUNT_RST;
    end else begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
    end
  end

  // status and target words, built from next values so reads are current
  // the word latched at the address phase matches the registers after it
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CBSU_STATUS_TAKEN_BIT] = taken_d;
    status_word[`CBSU_STATUS_SKIP_BIT] = skip_d;
    status_word[`CBSU_STATUS_STATE_LSB +: 3] = state_d;
    target_word = 32'h0000_0000;
    target_word[PC_W-1:0] = target_d;
  end

  // read mux and write capture; unmapped reads return zero
  // addresses above the low byte are outside the block: reads give zero,
  // writes are dropped, and the answer is still okay
  always_comb begin
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    rdata_d = rdata_q;
    if (addr_phase) begin
      wr_pend_d = hwrite_i;
      wr_addr_d = haddr_i[7:0];
      if (!hwrite_i) begin
        case (haddr_i[7:0])
          `CBSU_CTRL_OFS: rdata_d = ctrl_d;
          `CBSU_STATUS_OFS: rdata_d = status_word;
          `CBSU_COUNT_OFS: rdata_d = count_d;
          `CBSU_TARGET_OFS: rdata_d = target_word;
          default: rdata_d = 32'h0000_0000;
        endcase
        if (haddr_i[31:8] != 24'h00_0000) begin
          rdata_d = 32'h0000_0000;
        end
      end else if (haddr_i[31:8] != 24'h00_0000) begin
        wr_pend_d = 1'b0;
      end
    end
  end

  // bus capture registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait state slave, always OKAY
  // hsize_i is not decoded: every transfer is taken as a whole word
  assign hreadyout_o = 1'b1;
  assign hresp_o = `CBSU_HRESP_OKAY;
  assign hrdata_o = rdata_q;

endmodule

// [verif/cbsu_asserts.sv]
`timescale 1ns/1ps

// ==========
// port checks of the skip and branch unit
module cbsu_asserts
  import cbsu_pkg::*;
#(
  parameter int PC_W = 13
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [PC_W-1:0] program_counter_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic instr_ready_o,
  input wire logic stall_o,
  input wire logic done_o,
  input wire logic taken_o,
  input wire logic pc_load_o,
  input wire logic flush_o,
  input wire logic [PC_W-1:0] pc_next_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // accepted instruction, then its one-cycle finish
  sequence accept_s;
    instr_valid_i && instr_ready_o;
  endsequence
  sequence fall_s;
    accept_s ##1 done_o;
  endsequence
  sequence taken_s;
    accept_s ##1 (taken_o && stall_o);
  endsequence

  // ==========
  // assertions
  resp_ok_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not zero-wait okay");
  load_flush_a: assert property (pc_load_o == flush_o)
    else $error("flush differs from redirect");
  load_taken_a: assert property (pc_load_o |-> taken_o && done_o)
    else $error("redirect without taken finish");
  load_pulse_a: assert property (pc_load_o |=> !pc_load_o)
    else $error("redirect longer than a cycle");
  load_late_a: assert property (pc_load_o |-> $past(stall_o))
    else $error("redirect without busy cycle");
  fall_quiet_a: assert property (fall_s |-> !pc_load_o && !taken_o)
    else $error("one-cycle finish redirected");
  fall_pc_a: assert property (fall_s |-> pc_next_o == $past(program_counter_i) + 1'b1)
    else $error("fall-through address wrong");
  accept_done_a: assert property (accept_s |-> ##[1:3] done_o)
    else $error("no finish within three cycles");
  busy_ready_a: assert property (stall_o |-> !instr_ready_o)
    else $error("ready while busy");
  taken_flush_a: assert property (taken_s |-> ##[1:2] (pc_load_o && flush_o))
    else $error("taken verdict without flush");
endmodule

bind cbsu_top cbsu_asserts #(.PC_W(PC_W)) u_asserts (
  .clock_i,
  .rst_n_i,
  .instr_valid_i,
  .program_counter_i,
  .hreadyout_o,
  .hresp_o,
  .instr_ready_o,
  .stall_o,
  .done_o,
  .taken_o,
  .pc_load_o,
  .flush_o,
  .pc_next_o
);

// [verif/tb.sv]
`timescale 1ns/1ps
`include "cbsu_defs.svh"

// ==========
// bench of the skip and branch unit
module tb
  import cbsu_pkg::*;
;
  logic clock_i;
  logic rst_n_i;
  logic hsel, hwrite, hready, valid, two, iob;
  logic ready, done, taken, load, flush;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] flags;
  logic [6:0] ofs;
  logic [2:0] sel;
  logic [12:0] pc, pcn;
  cbsu_op_e op;
  int failures = 0;
  int check_count = 0;
  int nred = 0;
  logic [7:0] ftab [4] = '{8'h00, 8'hff, 8'h08, 8'h24};

  cbsu_top u_dut (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .hsel_i(hsel),
    .haddr_i(haddr),
    .htrans_i(htrans),
    .hwrite_i(hwrite),
    .hsize_i(3'h2),
    .hwdata_i(hwdata),
    .hready_i(hready),
    .hreadyout_o(hready),
    .hrdata_o(hrdata),
    .hresp_o(),
    .instr_valid_i(valid),
    .instr_op_i(op),
    .instr_sel_i(sel),
    .instr_offset_i(ofs),
    .next_two_word_i(two),
    .io_bit_i(iob),
    .status_flags_reg_i(flags),
    .program_counter_i(pc),
    .instr_ready_o(ready),
    .stall_o(),
    .done_o(done),
    .taken_o(taken),
    .pc_load_o(load),
    .flush_o(flush),
    .pc_next_o(pcn)
  );

  // 40 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // hang guard
  initial begin
    #(25 * 5000);
    failures++;
    final_report();
  end

  // ==========
  // helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_i); while (hready !== 1'b1);
    r = hrdata;
  endtask

  function automatic logic exp_take(cbsu_op_e o, logic [2:0] s, logic b, logic [7:0] f);
    case (o)
      skip_io_bit_clear: return !b;
      skip_io_bit_set: return b;
      branch_flag_set: return f[s];
      branch_flag_clear: return !f[s];
      branch_equal: return f[1];
      branch_not_equal: return !f[1];
      branch_carry_set: return f[0];
      branch_carry_clear: return !f[0];
      branch_same_or_higher: return !f[0];
      branch_lower: return f[0];
      branch_minus: return f[2];
      branch_plus: return !f[2];
      branch_signed_ge: return !(f[2] ^ f[3]);
      branch_signed_lt: return f[2] ^ f[3];
      branch_halfcarry_set: return f[5];
      default: return !f[5];
    endcase
  endfunction

  // ==========
  // scenarios
  task automatic t_regs();
    logic [31:0] r;
    bus(1'b0, `CBSU_CTRL_OFS, 32'h0, r);
    chk("ctrl", r, `CBSU_CTRL_RST);
    bus(1'b1, 32'h40, 32'hffff_ffff, r);
    bus(1'b0, 32'h40, 32'h0, r);
    chk("unmapped", r, 32'h0);
    bus(1'b1, `CBSU_CTRL_OFS, 32'h0, r);
    #1;
    chk("ready off", ready, 32'h0);
    @(posedge clock_i);
    bus(1'b1, `CBSU_CTRL_OFS, 32'h1, r);
  endtask

  // one instruction: i is the operation code, j picks flags and operands
  task automatic run(input int i, input int j);
    logic [6:0] k;
    logic [12:0] p, ep;
    logic et;
    int ec;
    int n;
    k = j[0] ? 7'h7d : 7'h05;
    p = 13'h100 + 13'(i);
    et = exp_take(cbsu_op_e'(i[4:0]), i[2:0], j[0], ftab[j]);
    ep = p + 13'h1;
    ec = 1;
    if (et && i < 2) begin
      ep = p + 13'h2 + 13'(j[1]);
      ec = 2 + j[1];
    end else if (et) begin
      ep = p + 13'h1 + {{6{k[6]}}, k};
      ec = 2;
    end
    @(posedge clock_i);
    valid <= 1'b1;
    op <= cbsu_op_e'(i[4:0]);
    sel <= i[2:0];
    ofs <= k;
    two <= j[1];
    iob <= j[0];
    flags <= ftab[j];
    pc <= p;
    #1;
    chk("ready", ready, 32'h1);
    @(posedge clock_i);
    valid <= 1'b0;
    n = 1;
    #1;
    while (done !== 1'b1 && n < 6) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk("cycles", n, ec);
    chk("taken", taken, et);
    chk("load", load, et);
    chk("flush", flush, et);
    chk("pc", pcn, ep);
    nred += et;
  endtask

  task automatic t_ops();
    logic [31:0] r;
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 4; j++) begin
        run(i, j);
      end
    end
    @(posedge clock_i);
    bus(1'b0, `CBSU_COUNT_OFS, 32'h0, r);
    chk("count", r, nred);
  endtask

  // status and target after a taken two-word skip, then a counter clear
  task automatic t_status();
    logic [31:0] r;
    logic [31:0] es;
    es = 32'(CBSU_ST_IDLE) << `CBSU_STATUS_STATE_LSB;
    es[`CBSU_STATUS_TAKEN_BIT] = 1'b1;
    es[`CBSU_STATUS_SKIP_BIT] = 1'b1;
    run(1, 3);
    @(posedge clock_i);
    bus(1'b0, `CBSU_STATUS_OFS, 32'h0, r);
    chk("status", r, es);
    bus(1'b0, `CBSU_TARGET_OFS, 32'h0, r);
    chk("target", r, 32'h0000_0101 + `CBSU_SKIP_TWO_WORD);
    bus(1'b1, `CBSU_COUNT_OFS, 32'h0, r);
    bus(1'b0, `CBSU_COUNT_OFS, 32'h0, r);
    chk("count clear", r, `CBSU_COUNT_RST);
  endtask

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    valid = 1'b0;
    op = branch_equal;
    sel = 3'h0;
    ofs = 7'h0;
    two = 1'b0;
    iob = 1'b0;
    flags = 8'h0;
    pc = 13'h0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_ops();
    t_status();
    final_report();
  end
endmodule
